// ==== standard_timer_operating_modes_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin bad_count++; $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end

module standard_timer_operating_modes_tb
  import stm_pkg::*;
();
  // ============================================================
  // Clock, reset and wiring
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  stm_bus_req_t req = '0;
  logic [31:0] rdata;
  logic wreq, ext_lvl = 1'b0, tio_lvl = 1'b0, ext_pin, tio_wire;
  logic pin_out, pin_oe_b;
  int bad_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [31:0] q, q2;
  int k;

  initial begin
    forever #12.5 mclk = ~mclk;
  end

  stm_timer i_stm_timer (.mclk_in(mclk), .rst_b_in(rst_b),
    .avs_req_in(req), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq), .external_clock_pin_in(ext_pin),
    .timer_io_pin_in(tio_wire), .timer_io_pin_out(pin_out),
    .timer_io_pin_oe_b_out(pin_oe_b));

  stm_pin_model i_stm_pin_model (.mclk_in(mclk), .ext_level_in(ext_lvl),
    .tio_level_in(tio_lvl), .pin_level_in(pin_out),
    .pin_oe_b_in(pin_oe_b), .external_clock_pin_out(ext_pin),
    .timer_io_pin_out(tio_wire));

  // ============================================================
  // Bus access and helpers
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge mclk);
    req <= '{address: a, read: ~w, write: w, writedata: d,
             byteenable: 4'hf};
    do begin
      @(posedge mclk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (n >= 50) begin
      bad_count++;
      $display("MISMATCH bus answer expected %h seen %h", 1'b0, wreq);
    end
    r = rdata;
    req <= '0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0, r);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  function automatic logic [31:0] cf(input logic [1:0] m, input logic [1:0] pf,
      input logic oc, input logic inv, input logic dpx, input logic ccl);
    return {24'h0, m, pf, oc, inv, dpx, ccl};
  endfunction

  task automatic setup(input logic [31:0] c, input logic [15:0] a,
                       input logic [7:0] p);
    wr(STM_ADDR_CTRL, 32'h0);
    wr(STM_ADDR_CFG, c);
    wr(STM_ADDR_CMPA, {16'h0, a});
    wr(STM_ADDR_CMPP, {24'h0, p});
    wr(STM_ADDR_STAT, 32'h3);
  endtask

  task automatic count_high(input int n, output int h);
    h = 0;
    repeat (n) begin
      @(posedge mclk);
      if (pin_out === 1'b1 && pin_oe_b === 1'b0) h++;
    end
  endtask

  // The window spans whole periods, so the count does not depend on phase.
  task automatic pwm_case(input logic [31:0] c, input logic [15:0] a,
      input logic [7:0] p, input int ex, input logic flags);
    int h;
    setup(c, a, p);
    wr(STM_ADDR_CTRL, 32'h1);
    tick(1100);
    count_high(1024, h);
    `CHK("pwm high cycles", ex, h)
    if (flags) begin
      rd(STM_ADDR_STAT, q);
      `CHK("pwm flags", 2'h3, q[1:0])
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  // ============================================================
  // Test sequence
  initial begin
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    for (int a = 0; a <= 'h18; a += 4) begin
      rd(a[4:0], q);
      `CHK("reset value", 32'h0, q)
    end
    wr(5'h18, 32'hffffffff);
    rd(5'h18, q);
    `CHK("unmapped", 32'h0, q)
    $display("test reset done");

    setup(cf(STM_MODE_CMP, STM_CMP_LOW, 1, 0, 0, 1), 16'd300, 8'h01);
    wr(STM_ADDR_CTRL, 32'h1);
    tick(6);
    `CHK("cmp initial", 1'b1, pin_out)
    `CHK("cmp oe", 1'b0, pin_oe_b)
    tick(350);
    `CHK("cmp after match", 1'b0, pin_out)
    rd(STM_ADDR_STAT, q);
    `CHK("cmp flags", 2'h1, q[1:0])
    rd(STM_ADDR_CNT, q);
    `CHK("cmp clear on a", 1'b1, q < 300)
    wr(STM_ADDR_CTRL, 32'h0);
    rd(STM_ADDR_CNT, q);
    tick(5);
    rd(STM_ADDR_CNT, q2);
    `CHK("count held", q, q2)
    wr(STM_ADDR_CTRL, 32'h1);
    tick(6);
    `CHK("cmp restart", 1'b1, pin_out)
    $display("test compare done");

    setup(cf(STM_MODE_TC, STM_CMP_LOW, 1, 0, 0, 0), 16'd100, 8'h01);
    wr(STM_ADDR_CTRL, 32'h1);
    k = 0;
    repeat (300) begin
      @(posedge mclk);
      if (pin_oe_b !== 1'b1) k++;
    end
    `CHK("tc driven cycles", 0, k)
    rd(STM_ADDR_STAT, q);
    `CHK("tc flags", 2'h3, q[1:0])
    $display("test timer counter done");

    pwm_case(cf(STM_MODE_PWM, STM_PF_WAVE, 1, 0, 0, 0), 64, 1, 256, 1);
    pwm_case(cf(STM_MODE_PWM, STM_PF_WAVE, 1, 0, 0, 1), 64, 1, 256, 0);
    pwm_case(cf(STM_MODE_PWM, STM_PF_WAVE, 1, 1, 0, 0), 64, 1, 768, 0);
    pwm_case(cf(STM_MODE_PWM, STM_PF_WAVE, 0, 0, 0, 0), 64, 1, 768, 0);
    pwm_case(cf(STM_MODE_PWM, STM_PF_WAVE, 1, 0, 0, 0), 300, 1, 1024, 0);
    pwm_case(cf(STM_MODE_PWM, STM_PF_WAVE, 1, 0, 1, 0), 1024, 1, 256, 1);
    pwm_case(cf(STM_MODE_PWM, STM_PF_INACTIVE, 1, 0, 0, 0), 64, 1, 0, 1);
    pwm_case(cf(STM_MODE_PWM, STM_PF_ACTIVE, 1, 0, 0, 0), 64, 1, 1024, 1);
    $display("test pwm done");

    setup(cf(STM_MODE_PWM, STM_PF_PULSE, 1, 0, 1, 1), 16'd50, 8'h00);
    ext_lvl <= 1'b1;
    count_high(200, k);
    `CHK("pulse width", 1'b1, k >= 50 && k <= 52)
    rd(STM_ADDR_CTRL, q);
    `CHK("pulse run cleared", 1'b0, q[0])
    rd(STM_ADDR_STAT, q);
    `CHK("pulse flag", 1'b1, q[0])
    rd(STM_ADDR_CNT, q);
    tick(10);
    rd(STM_ADDR_CNT, q2);
    `CHK("pulse count held", q, q2)
    ext_lvl <= 1'b0;
    wr(STM_ADDR_CTRL, 32'h1);
    tick(5);
    `CHK("soft pulse start", 1'b1, pin_out)
    wr(STM_ADDR_CTRL, 32'h0);
    tick(3);
    `CHK("soft pulse end", 1'b0, pin_out)
    rd(STM_ADDR_CNT, q);
    `CHK("restart from zero", 1'b1, q < 32'd49)
    $display("test single pulse done");

    for (int c = 0; c < 4; c++) begin
      setup(cf(STM_MODE_CAP, c[1:0], 1, 1, 1, 1), 16'hbeef, 8'h01);
      wr(STM_ADDR_CTRL, 32'h1);
      tick(20);
      tio_lvl <= 1'b1;
      tick(10);
      rd(STM_ADDR_CMPA, q);
      k = (c == STM_CAP_RISE || c == STM_CAP_BOTH);
      `CHK("capture on rise", k ? 8'h00 : 8'hbe, q[15:8])
      rd(STM_ADDR_STAT, q);
      `CHK("capture flag", k[0], q[0])
      wr(STM_ADDR_CMPA, 32'hbeef);
      wr(STM_ADDR_STAT, 32'h3);
      tio_lvl <= 1'b0;
      tick(10);
      rd(STM_ADDR_CMPA, q);
      k = (c == STM_CAP_FALL || c == STM_CAP_BOTH);
      `CHK("capture on fall", k ? 8'h00 : 8'hbe, q[15:8])
      `CHK("capture no drive", 1'b1, pin_oe_b)
      rd(STM_ADDR_CNT, q);
      tick(300);
      rd(STM_ADDR_CNT, q2);
      `CHK("capture counting", 1'b1, q !== q2)
      rd(STM_ADDR_STAT, q);
      `CHK("capture wrap flag", 1'b1, q[1])
    end
    $display("test capture done");
    tally_and_finish();
  end
endmodule

`default_nettype wire

// ==== stm_pin_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Pin side model
// The shared pin shows the timer's level while the timer drives it and
// the outside level otherwise, so a capture never sees a stale echo.
module stm_pin_model (
  input wire logic mclk_in,
  input wire logic ext_level_in,
  input wire logic tio_level_in,
  input wire logic pin_level_in,
  input wire logic pin_oe_b_in,
  output logic external_clock_pin_out,
  output logic timer_io_pin_out
);
  logic ext_q = 1'b0;
  logic tio_q = 1'b0;
  always_ff @(posedge mclk_in) begin
    ext_q <= ext_level_in;
    tio_q <= tio_level_in;
  end
  assign external_clock_pin_out = ext_q;
  assign timer_io_pin_out = (pin_oe_b_in == 1'b0) ? pin_level_in : tio_q;
endmodule

`default_nettype wire

// ==== stm_pkg.sv ====
package stm_pkg;

  // ==========================================================================
  // Register map (byte addresses) and fields
  localparam logic [4:0] STM_ADDR_CTRL = 5'h00;
  localparam logic [4:0] STM_ADDR_CFG = 5'h04;
  localparam logic [4:0] STM_ADDR_CMPA = 5'h08;
  localparam logic [4:0] STM_ADDR_CMPP = 5'h0c;
  localparam logic [4:0] STM_ADDR_CNT = 5'h10;
  localparam logic [4:0] STM_ADDR_STAT = 5'h14;
  localparam int STM_CTRL_RUN_POS = 0;
  localparam int STM_STAT_A_POS = 0;
  localparam int STM_STAT_P_POS = 1;

  // ==========================================================================
  // Mode and pin function codes
  localparam logic [1:0] STM_MODE_CMP = 2'h0;
  localparam logic [1:0] STM_MODE_CAP = 2'h1;
  localparam logic [1:0] STM_MODE_PWM = 2'h2;
  localparam logic [1:0] STM_MODE_TC = 2'h3;
  localparam logic [1:0] STM_PF_INACTIVE = 2'h0;
  localparam logic [1:0] STM_PF_ACTIVE = 2'h1;
  localparam logic [1:0] STM_PF_WAVE = 2'h2;
  localparam logic [1:0] STM_PF_PULSE = 2'h3;
  localparam logic [1:0] STM_CMP_NONE = 2'h0;
  localparam logic [1:0] STM_CMP_LOW = 2'h1;
  localparam logic [1:0] STM_CMP_HIGH = 2'h2;
  localparam logic [1:0] STM_CMP_TOGGLE = 2'h3;
  localparam logic [1:0] STM_CAP_RISE = 2'h0;
  localparam logic [1:0] STM_CAP_FALL = 2'h1;
  localparam logic [1:0] STM_CAP_BOTH = 2'h2;
  localparam logic [1:0] STM_CAP_NONE = 2'h3;
  localparam logic [16:0] STM_FULL_SPAN = 17'h10000;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] pf;
    logic oc;
    logic inv;
    logic dpx;
    logic ccl;
  } stm_cfg_t;

  typedef struct packed {
    logic [4:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } stm_bus_req_t;

  typedef struct packed {
    stm_cfg_t cfg;
    logic run;
    logic run_d;
    logic [15:0] cnt;
    logic [15:0] ca;
    logic [7:0] cp;
    logic flag_a;
    logic flag_p;
    logic pin;
    logic out;
    logic oe_b;
    logic tio_s1;
    logic tio_s2;
    logic tio_d;
    logic tck_s1;
    logic tck_s2;
    logic tck_d;
    logic ack;
    logic [31:0] rdata;
  } stm_state_t;

  localparam stm_state_t STM_STATE_RST = '{oe_b: 1'b1, default: '0};

endpackage

// ==== stm_timer.sv ====
`timescale 1ns/1ps
`default_nettype none

module stm_timer
  import stm_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire stm_bus_req_t avs_req_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic external_clock_pin_in,
  input wire logic timer_io_pin_in,
  output logic timer_io_pin_out,
  output logic timer_io_pin_oe_b_out
);

  // ==========================================================================
  // Helpers
  // A comparator matches on the last count before its value, so a value of
  // v gives exactly v clocks per period and zero wraps to the full range.
  function automatic logic hits(input logic [15:0] c, input logic [15:0] v);
    hits = (c + 16'h0001) == v;
  endfunction

  function automatic logic [16:0] span(input logic [15:0] v);
    span = (v == 16'h0000) ? STM_FULL_SPAN : {1'b0, v};
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  stm_state_t s;
  stm_state_t next_s;

  logic bus_wr;
  logic run_rise;
  logic go;
  logic sp_mode;
  logic a_match;
  logic p_match;
  logic clr;
  logic tio_rise;
  logic tio_fall;
  logic cap_edge;
  logic [16:0] period;
  logic [16:0] duty;
  logic full_duty;
  logic wave_act;
  logic [31:0] rd;

  // ==========================================================================
  // Combinational decode of the present state
  always_comb begin
    bus_wr = avs_req_in.write & s.ack;
    run_rise = s.run & ~s.run_d;
    go = s.run & s.run_d;
    sp_mode = (s.cfg.mode == STM_MODE_PWM) && (s.cfg.pf == STM_PF_PULSE);
    a_match = hits(s.cnt, s.ca);
    p_match = hits(s.cnt, {s.cp, 8'h00});
    tio_rise = s.tio_s2 & ~s.tio_d;
    tio_fall = ~s.tio_s2 & s.tio_d;
    case (s.cfg.pf)
      STM_CAP_RISE: cap_edge = tio_rise;
      STM_CAP_FALL: cap_edge = tio_fall;
      STM_CAP_BOTH: cap_edge = tio_rise | tio_fall;
      default: cap_edge = 1'b0;
    endcase
    if (s.cfg.dpx) begin
      period = span(s.ca);
      duty = span({s.cp, 8'h00});
    end else begin
      period = span({s.cp, 8'h00});
      duty = {1'b0, s.ca};
    end
    full_duty = duty >= period;
    wave_act = full_duty | ({1'b0, s.cnt} < duty);
    // the clear source follows the mode.
    case (s.cfg.mode)
      STM_MODE_CAP: clr = p_match;
      STM_MODE_PWM: begin
        if (sp_mode) begin
          clr = 1'b0;
        end else begin
          clr = s.cfg.dpx ? a_match : p_match;
        end
      end
      default: clr = s.cfg.ccl ? a_match : p_match;
    endcase
    rd = 32'h0000_0000;
    if (avs_req_in.address == STM_ADDR_CTRL) begin
      rd[STM_CTRL_RUN_POS] = s.run;
    end else if (avs_req_in.address == STM_ADDR_CFG) begin
      rd[7:0] = s.cfg;
    end else if (avs_req_in.address == STM_ADDR_CMPA) begin
      rd[15:0] = s.ca;
    end else if (avs_req_in.address == STM_ADDR_CMPP) begin
      rd[7:0] = s.cp;
    end else if (avs_req_in.address == STM_ADDR_CNT) begin
      rd[15:0] = s.cnt;
    end else if (avs_req_in.address == STM_ADDR_STAT) begin
      rd[STM_STAT_A_POS] = s.flag_a;
      rd[STM_STAT_P_POS] = s.flag_p;
    end
  end

  // ==========================================================================
  // Next state
  always_comb begin
    next_s = s;
    next_s.tio_s1 = timer_io_pin_in;
    next_s.tio_s2 = s.tio_s1;
    next_s.tio_d = s.tio_s2;
    next_s.tck_s1 = external_clock_pin_in;
    next_s.tck_s2 = s.tck_s1;
    next_s.tck_d = s.tck_s2;
    next_s.run_d = s.run;
    // One wait state lets read data come from a flip-flop.
    next_s.ack = (avs_req_in.read | avs_req_in.write) & ~s.ack;
    if (avs_req_in.read & ~s.ack) begin
      next_s.rdata = rd;
    end
    if (bus_wr) begin
      if (avs_req_in.address == STM_ADDR_CTRL) begin
        if (avs_req_in.byteenable[0]) begin
          next_s.run = avs_req_in.writedata[STM_CTRL_RUN_POS];
        end
      end else if (avs_req_in.address == STM_ADDR_CFG) begin
        if (avs_req_in.byteenable[0]) begin
          next_s.cfg = avs_req_in.writedata[7:0];
        end
      end else if (avs_req_in.address == STM_ADDR_CMPA) begin
        next_s.ca = merge16(s.ca, avs_req_in.writedata,
                            avs_req_in.byteenable);
      end else if (avs_req_in.address == STM_ADDR_CMPP) begin
        if (avs_req_in.byteenable[0]) begin
          next_s.cp = avs_req_in.writedata[7:0];
        end
      end else if (avs_req_in.address == STM_ADDR_STAT) begin
        if (avs_req_in.byteenable[0]) begin
          next_s.flag_a = s.flag_a & ~avs_req_in.writedata[STM_STAT_A_POS];
          next_s.flag_p = s.flag_p & ~avs_req_in.writedata[STM_STAT_P_POS];
        end
      end
    end
    // An external edge restarts the pulse only while idle.
    if (sp_mode && s.tck_s2 && !s.tck_d && !s.run) begin
      next_s.run = 1'b1;
    end
    if (run_rise) begin
      next_s.cnt = 16'h0000;
      if (s.cfg.mode == STM_MODE_CMP) begin
        next_s.pin = s.cfg.oc;
      end
    end else if (go) begin
      next_s.cnt = clr ? 16'h0000 : s.cnt + 16'h0001;
      // Hardware events are applied after the bus so a set beats a clear.
      case (s.cfg.mode)
        STM_MODE_CAP: begin
          if (p_match) begin
            next_s.flag_p = 1'b1;
          end
          if (cap_edge) begin
            next_s.ca = s.cnt;
            next_s.flag_a = 1'b1;
          end
        end
        STM_MODE_PWM: begin
          if (a_match) begin
            next_s.flag_a = 1'b1;
          end
          if (sp_mode) begin
            if (a_match) begin
              next_s.run = 1'b0;
            end
          end else if (p_match) begin
            next_s.flag_p = 1'b1;
          end
        end
        default: begin
          if (a_match) begin
            next_s.flag_a = 1'b1;
          end
          if (p_match && !s.cfg.ccl) begin
            next_s.flag_p = 1'b1;
          end
          if (a_match && s.cfg.mode == STM_MODE_CMP) begin
            case (s.cfg.pf)
              STM_CMP_LOW: next_s.pin = 1'b0;
              STM_CMP_HIGH: next_s.pin = 1'b1;
              STM_CMP_TOGGLE: next_s.pin = ~s.pin;
              default: next_s.pin = s.pin;
            endcase
          end
        end
      endcase
    end
    // Pin drive is registered from the present state, one clock behind.
    case (s.cfg.mode)
      STM_MODE_CMP: begin
        next_s.out = s.pin ^ s.cfg.inv;
        next_s.oe_b = 1'b0;
      end
      STM_MODE_PWM: begin
        case (s.cfg.pf)
          STM_PF_INACTIVE: next_s.out = ~s.cfg.oc ^ s.cfg.inv;
          STM_PF_ACTIVE: next_s.out = s.cfg.oc ^ s.cfg.inv;
          STM_PF_WAVE: next_s.out = (wave_act ~^ s.cfg.oc) ^ s.cfg.inv;
          default: next_s.out = (s.run ~^ s.cfg.oc) ^ s.cfg.inv;
        endcase
        next_s.oe_b = 1'b0;
      end
      default: begin
        next_s.out = 1'b0;
        next_s.oe_b = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      s <= STM_STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  assign avs_waitrequest_out = (avs_req_in.read | avs_req_in.write) & ~s.ack;
  assign avs_readdata_out = s.rdata;
  assign timer_io_pin_out = s.out;
  assign timer_io_pin_oe_b_out = s.oe_b;

  // ==========================================================================
  // Checks
  property p_tc_no_drive;
    @(posedge mclk_in) disable iff (!rst_b_in)
    s.cfg.mode == STM_MODE_TC |=> timer_io_pin_oe_b_out;
  endproperty
  a_tc_no_drive: assert property (p_tc_no_drive)
    else $error("Pin driven in timer/counter mode.");

  property p_no_pflag_on_a_clear;
    @(posedge mclk_in) disable iff (!rst_b_in)
    (s.cfg.mode == STM_MODE_CMP || s.cfg.mode == STM_MODE_TC)
      && s.cfg.ccl && !s.flag_p |=> !s.flag_p;
  endproperty
  a_no_pflag_on_a_clear: assert property (p_no_pflag_on_a_clear)
    else $error("P flag set while A match clears the counter.");

  property p_cmp_init_level;
    @(posedge mclk_in) disable iff (!rst_b_in)
    s.cfg.mode == STM_MODE_CMP && run_rise |=> s.pin == $past(s.cfg.oc);
  endproperty
  a_cmp_init_level: assert property (p_cmp_init_level)
    else $error("Pin not reset to initial level on run rise.");

  property p_pwm_flags;
    @(posedge mclk_in) disable iff (!rst_b_in)
    s.cfg.mode == STM_MODE_PWM && !sp_mode && go && p_match |=> s.flag_p;
  endproperty
  a_pwm_flags: assert property (p_pwm_flags)
    else $error("P match flag missing in PWM mode.");

  property p_full_duty;
    @(posedge mclk_in) disable iff (!rst_b_in)
    s.cfg.mode == STM_MODE_PWM && s.cfg.pf == STM_PF_WAVE && full_duty
      |=> timer_io_pin_out == $past(s.cfg.oc ^ s.cfg.inv);
  endproperty
  a_full_duty: assert property (p_full_duty)
    else $error("Full duty not held active.");

  property p_pulse_end;
    @(posedge mclk_in) disable iff (!rst_b_in)
    sp_mode && go && a_match |=> !s.run ##1 !s.run_d;
  endproperty
  a_pulse_end: assert property (p_pulse_end)
    else $error("A match did not end the single pulse.");

  property p_capture;
    @(posedge mclk_in) disable iff (!rst_b_in)
    s.cfg.mode == STM_MODE_CAP && go && cap_edge
      |=> s.ca == $past(s.cnt) && s.flag_a;
  endproperty
  a_capture: assert property (p_capture)
    else $error("Capture did not latch the counter.");

  property p_cap_wrap;
    @(posedge mclk_in) disable iff (!rst_b_in)
    s.cfg.mode == STM_MODE_CAP && go && p_match |=> s.cnt == 16'h0000;
  endproperty
  a_cap_wrap: assert property (p_cap_wrap)
    else $error("Capture counter did not wrap on P match.");

  property p_cap_off;
    @(posedge mclk_in) disable iff (!rst_b_in)
    s.cfg.mode == STM_MODE_CAP && s.cfg.pf == STM_CAP_NONE
      && !(bus_wr && avs_req_in.address == STM_ADDR_CMPA) |=> $stable(s.ca);
  endproperty
  a_cap_off: assert property (p_cap_off)
    else $error("Capture happened while disabled.");

  property p_run_rise_zero;
    @(posedge mclk_in) disable iff (!rst_b_in)
    run_rise |=> s.cnt == 16'h0000;
  endproperty
  a_run_rise_zero: assert property (p_run_rise_zero)
    else $error("Counter not zeroed on run rise.");

  // An external edge while idle must raise the run bit on the next clock.
  property p_pulse_start;
    @(posedge mclk_in) disable iff (!rst_b_in)
    sp_mode && s.tck_s2 && !s.tck_d && !s.run |=> s.run;
  endproperty
  a_pulse_start: assert property (p_pulse_start)
    else $error("External edge did not start the pulse.");

  property p_count_hold;
    @(posedge mclk_in) disable iff (!rst_b_in)
    sp_mode && !go && !run_rise |=> $stable(s.cnt);
  endproperty
  a_count_hold: assert property (p_count_hold)
    else $error("Idle single pulse counter moved.");

  property p_pwm_forced;
    @(posedge mclk_in) disable iff (!rst_b_in)
    s.cfg.mode == STM_MODE_PWM && s.cfg.pf == STM_PF_ACTIVE
      |=> timer_io_pin_out == $past(s.cfg.oc ^ s.cfg.inv);
  endproperty
  a_pwm_forced: assert property (p_pwm_forced)
    else $error("Forced active level not driven.");

  property p_cap_no_drive;
    @(posedge mclk_in) disable iff (!rst_b_in)
    s.cfg.mode == STM_MODE_CAP |=> timer_io_pin_oe_b_out;
  endproperty
  a_cap_no_drive: assert property (p_cap_no_drive)
    else $error("Pin driven in capture mode.");

  property p_swap_period;
    @(posedge mclk_in) disable iff (!rst_b_in)
    s.cfg.mode == STM_MODE_PWM && !sp_mode && s.cfg.dpx && go && a_match
      |=> s.cnt == 16'h0000;
  endproperty
  a_swap_period: assert property (p_swap_period)
    else $error("A match did not end the swapped period.");

endmodule

`default_nettype wire
